/* File: common/gpio_port_pkg.sv */
// Package with the register map, field layout and reset values of the port.
`default_nettype none
package gpio_port_pkg;
    // Byte offsets of the registers on the APB bus.
    localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
    localparam logic [7:0] OFS_LATCH = 8'h04;
    localparam logic [7:0] OFS_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_SHARED_LOW = 8'h0C;
    localparam logic [7:0] OFS_SHARED_HIGH = 8'h10;
    localparam logic [7:0] OFS_WATCHDOG = 8'h14;
    localparam logic [7:0] OFS_OVERRIDE = 8'h18;

    // Shared-register select bit inside the watchdog control register.
    localparam int SHARED_SEL_BIT = 4;

    // Bits that exist in each register; the rest read as zero.
    localparam logic [7:0] PORT_MASK = 8'hFE;
    localparam logic [7:0] ANALOG_LOW_MASK = 8'hDF;
    localparam logic [7:0] ANALOG_HIGH_MASK = 8'hFF;
    localparam logic [7:0] OVERRIDE_MASK = 8'h1F;

    // Reset values: latch clear, all lines input, all channels analog.
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'hFE;
    localparam logic [7:0] ANALOG_LOW_RESET = 8'h00;
    localparam logic [7:0] ANALOG_HIGH_RESET = 8'h00;
    localparam logic [7:0] DEFAULT_REG_RESET = 8'h00;
    localparam logic [7:0] WATCHDOG_RESET = 8'h00;
    localparam logic [7:0] OVERRIDE_RESET = 8'h00;

    // Channel-select bits: lines one and two sit in the low register at
    // bits six and seven, lines three to six in the high register at 0..3.
    localparam int LOW_CH_FIRST = 6;
    localparam int HIGH_CH_FIRST = 0;

    // Override control fields.
    localparam int OVR_COMP1_EN = 0;
    localparam int OVR_COMP2_EN = 1;
    localparam int OVR_ADDR5_EN = 2;
    localparam int OVR_COMPARATOR_REFERENCE_OUTPUT_EN = 3;
    localparam int OVR_PDATA_EN = 4;

    // Line numbers that carry peripheral functions.
    localparam int LINE_COMP2 = 1;
    localparam int LINE_ADDR5 = 2;
    localparam int LINE_COMPARATOR_REFERENCE_OUTPUT = 5;
    localparam int LINE_PDATA_LOW = 5;
    localparam int LINE_PDATA_HIGH = 7;
endpackage : gpio_port_pkg
`default_nettype wire

/* File: hdl/gpio_port.sv */
// Seven-line general-purpose port with analog select and peripheral overrides.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:1] pin_in,
    output logic [7:1] pin_out,
    output logic [7:1] pin_oe,
    output logic [6:1] analog_enable,
    input wire logic parallel_port_placement_bit,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic parallel_address_bit_five,
    input wire logic [2:0] parallel_data_out,
    input wire logic parallel_data_drive,
    output logic [2:0] parallel_data_in,
    output logic comparator_reference_output
);

    // Refuse an address bus too narrow for the register map.
    if (ADDR_WIDTH < 5) begin : g_addr_check
        $error("gpio_port: ADDR_WIDTH must be at least 5");
    end

    // Register map as software sees it, one byte register per word.
    // The pin offset reads the levels at the pins after the input gate.
    // A write at the pin offset loads the output latch, as a latch write.
    // The latch offset reads back what the latch holds, not the pins.
    // The direction offset holds one bit per line, where 1 means input.
    // The two shared offsets lead to the channel-select pair only while
    // the shared select bit of watchdog control is set.
    // With that bit clear the same offsets reach two scratch registers.
    // Software must therefore set the bit, touch the select pair and
    // clear the bit again, or later scratch accesses go astray.
    // The override register enables the peripheral functions per line.
    // Bits that have no storage are masked both on write and on read.
    // Bit zero of the pin, latch and direction registers does not exist.
    // Bit five of the low select register does not exist either.
    // An address outside the map answers with pslverr and read data 0.
    // A write to such an address changes nothing at all.
    //
    // Timing of the bus side, seen from the master.
    // The setup cycle latches nothing; the first access cycle computes
    // the answer and the second access cycle shows it on pready.
    // A write takes effect at the edge that ends the second cycle.
    // Read data are taken from the state of the first access cycle.
    // Because the master holds the request, that state cannot change
    // between the two cycles except through the pins themselves.
    // A pin read therefore shows levels one cycle older than the edge.
    //
    // Pin side timing.
    // Pin drive and enable are registered, so a register write shows
    // at the pins one cycle after the edge at which it lands.
    // Peripheral overrides follow the same single-cycle delay.
    // The converter enables are registered as well, which keeps every
    // output of the port glitch-free towards the analog multiplexer.

    // Decodes a byte offset against the whole address bus.
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a[ADDR_WIDTH-1:0] == ADDR_WIDTH'(ofs));
    endfunction : hit

    // Software-visible state.
    logic [7:0] output_latch_register;
    logic [7:0] direction_register;
    logic [7:0] analog_select_low;
    logic [7:0] analog_select_high;
    logic [7:0] default_low;
    logic [7:0] default_high;
    logic [7:0] watchdog_control_register;
    logic [7:0] override_control;

    // Bus phase decode.
    wire logic access = psel & penable;
    wire logic commit = access & pready;
    wire logic wr_commit = commit & pwrite;
    wire logic shared_register_select =
        watchdog_control_register[SHARED_SEL_BIT];

    // Address decode; shared offsets switch target on the select bit.
    wire logic hit_pin = hit(paddr, OFS_PIN_LEVEL);
    wire logic hit_latch = hit(paddr, OFS_LATCH);
    wire logic hit_dir = hit(paddr, OFS_DIRECTION);
    wire logic hit_shared_low = hit(paddr, OFS_SHARED_LOW);
    wire logic hit_shared_high = hit(paddr, OFS_SHARED_HIGH);
    wire logic hit_wdt = hit(paddr, OFS_WATCHDOG);
    wire logic hit_ovr = hit(paddr, OFS_OVERRIDE);
    wire logic hit_any = hit_pin | hit_latch | hit_dir | hit_shared_low |
                         hit_shared_high | hit_wdt | hit_ovr;
    wire logic [7:0] wbyte = pwdata[7:0];

    // Channel-select bits gathered per line; a set bit means digital.
    wire logic [6:1] channel_digital_select = {
        analog_select_high[HIGH_CH_FIRST+3],
        analog_select_high[HIGH_CH_FIRST+2],
        analog_select_high[HIGH_CH_FIRST+1],
        analog_select_high[HIGH_CH_FIRST],
        analog_select_low[LOW_CH_FIRST+1],
        analog_select_low[LOW_CH_FIRST]
    };
    wire logic [7:1] line_is_analog = {1'b0, ~channel_digital_select};

    // Override enables.
    wire logic comp1_en = override_control[OVR_COMP1_EN];
    wire logic comp2_en = override_control[OVR_COMP2_EN];
    wire logic addr5_en = override_control[OVR_ADDR5_EN];
    wire logic comparator_reference_output_en = override_control[OVR_COMPARATOR_REFERENCE_OUTPUT_EN];
    wire logic pdata_on = LARGE_PACKAGE & ~parallel_port_placement_bit &
                          override_control[OVR_PDATA_EN];

    // Priority of the functions that can claim one line, highest first.
    // The reference output turns the digital driver and input off.
    // Parallel data then takes lines seven, six and five both ways.
    // The parallel address bit then drives line two as an output.
    // A comparator output then drives its own line as an output.
    // Only when no function claims the line do latch and direction act.
    // The peripherals set the direction themselves, so software can
    // keep the direction register as it wants it while they run.
    // The override value is never written back into that register,
    // which keeps read-modify-write sequences on it safe.
    // Parallel data needs the large package, the placement bit at 0
    // and its override enable; any one missing leaves the lines free.
    // The parallel port decides the drive of its three lines with a
    // single enable, so all three turn around together.
    // The analog select never changes what an output line drives.
    // It only gates the digital input path of the line, so a line that
    // is analog reads as 0 while the converter sees the pin level.
    // Line seven has no analog channel and its input stays enabled.

    // Per-line driver selection, highest priority first.
    logic [7:1] next_pin_out;
    logic [7:1] next_pin_oe;
    logic [7:1] input_enable;
    for (genvar i = 1; i <= 7; i++) begin : g_line
        wire logic pdata_line = pdata_on && (i >= LINE_PDATA_LOW) &&
                                (i <= LINE_PDATA_HIGH);
        wire logic comparator_reference_output_line = comparator_reference_output_en && (i == LINE_COMPARATOR_REFERENCE_OUTPUT);
        wire logic comp_line = (comp2_en && (i == LINE_COMP2)) ||
                               (comp1_en && (i == LINE_ADDR5));
        wire logic addr_line = addr5_en && (i == LINE_ADDR5);
        wire logic comp_val = (i == LINE_COMP2) ? comparator_two_output
                                                : comparator_one_output;
        wire logic pdata_val =
            parallel_data_out[(LINE_PDATA_HIGH - i) % 3];

        // Digital output: latch unless a peripheral takes the pin.
        assign next_pin_out[i] =
            comparator_reference_output_line ? 1'b0 :
            pdata_line ? pdata_val :
            addr_line ? parallel_address_bit_five :
            comp_line ? comp_val :
            output_latch_register[i];

        // Enable: direction bit unless overridden by a peripheral.
        assign next_pin_oe[i] =
            comparator_reference_output_line ? 1'b0 :
            pdata_line ? parallel_data_drive :
            (addr_line | comp_line) ? 1'b1 :
            ~direction_register[i];

        // Digital input path off while analog or reference is on.
        assign input_enable[i] = ~line_is_analog[i] & ~comparator_reference_output_line;
    end

    // Pin levels as software sees them.
    wire logic [7:0] pin_read = {pin_in & input_enable, 1'b0} & PORT_MASK;

    // Read multiplexer; shared offsets pick by the select bit.
    wire logic [7:0] low_read = shared_register_select ?
        (analog_select_low & ANALOG_LOW_MASK) : default_low;
    wire logic [7:0] high_read = shared_register_select ?
        (analog_select_high & ANALOG_HIGH_MASK) : default_high;
    wire logic [7:0] read_byte =
        hit_pin ? pin_read :
        hit_latch ? (output_latch_register & PORT_MASK) :
        hit_dir ? (direction_register & PORT_MASK) :
        hit_shared_low ? low_read :
        hit_shared_high ? high_read :
        hit_wdt ? watchdog_control_register :
        hit_ovr ? (override_control & OVERRIDE_MASK) : 8'h00;

    // The slave answers with a fixed wait of one cycle.
    // The wait gives the read multiplexer a full cycle before the data
    // are registered, which keeps the long decode chain off the bus.
    // pready rises only after an access cycle without pready, so a
    // master that keeps penable high cannot get two answers in a row.
    // pslverr and prdata rise and fall together with pready.
    // Read data are zero whenever pready is low, so a master that
    // samples early reads a harmless 0 rather than stale data.

    // Answer one cycle into the access phase.
    wire logic next_pready = access & ~pready;

    // Bus answer registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pready & ~hit_any;
            prdata <= (next_pready & ~pwrite) ? {24'h00_0000, read_byte}
                                              : 32'h0000_0000;
        end
    end

    // Latch: written at the pin offset or the latch offset.
    always_ff @(posedge clk) begin
        if (srst) begin
            output_latch_register <= LATCH_RESET;
        end else if (wr_commit && (hit_pin || hit_latch)) begin
            output_latch_register <= wbyte & PORT_MASK;
        end
    end

    // Direction register.
    always_ff @(posedge clk) begin
        if (srst) begin
            direction_register <= DIRECTION_RESET;
        end else if (wr_commit && hit_dir) begin
            direction_register <= wbyte & PORT_MASK;
        end
    end

    // Analog select registers, reachable only with the select bit set.
    always_ff @(posedge clk) begin
        if (srst) begin
            analog_select_low <= ANALOG_LOW_RESET;
            analog_select_high <= ANALOG_HIGH_RESET;
        end else if (wr_commit && shared_register_select) begin
            if (hit_shared_low) begin
                analog_select_low <= wbyte & ANALOG_LOW_MASK;
            end
            if (hit_shared_high) begin
                analog_select_high <= wbyte & ANALOG_HIGH_MASK;
            end
        end
    end

    // Default registers at the same offsets, seen with the bit clear.
    always_ff @(posedge clk) begin
        if (srst) begin
            default_low <= DEFAULT_REG_RESET;
            default_high <= DEFAULT_REG_RESET;
        end else if (wr_commit && !shared_register_select) begin
            if (hit_shared_low) begin
                default_low <= wbyte;
            end
            if (hit_shared_high) begin
                default_high <= wbyte;
            end
        end
    end

    // Watchdog control and override control registers.
    always_ff @(posedge clk) begin
        if (srst) begin
            watchdog_control_register <= WATCHDOG_RESET;
            override_control <= OVERRIDE_RESET;
        end else if (wr_commit) begin
            if (hit_wdt) begin
                watchdog_control_register <= wbyte;
            end
            if (hit_ovr) begin
                override_control <= wbyte & OVERRIDE_MASK;
            end
        end
    end

    // Every output of the port comes from a flip-flop.
    // During reset no line is driven, so the board sees inputs only.
    // All six analog lines come up as converter inputs, one channel
    // per line in ascending order, until software selects digital use.
    // The parallel data input reads 0 while parallel data are off, so
    // the parallel port never sees pin noise from a line it gave up.
    // The reference flag follows its override bit with one cycle delay,
    // in step with the pin enable that it turns off.
    // Line seven maps to parallel bit zero and line five to bit two.
    // Because the enables are registered with the drive, the pin and
    // its enable always change at the same edge.

    // Pin drivers and peripheral-facing outputs, all registered.
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out <= 7'h00;
            pin_oe <= 7'h00;
            analog_enable <= 6'h3F;
            parallel_data_in <= 3'h0;
            comparator_reference_output <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            analog_enable <= line_is_analog[6:1];
            parallel_data_in <= pdata_on ?
                {pin_in[LINE_PDATA_LOW], pin_in[LINE_PDATA_LOW+1],
                 pin_in[LINE_PDATA_HIGH]} : 3'h0;
            comparator_reference_output <= comparator_reference_output_en;
        end
    end

endmodule : gpio_port
`default_nettype wire

/* File: tb/gpio_port_assertions.sv */
// Checker of bus timing, reset state and pin overrides of the port.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_assertions #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:1] pin_oe,
    input wire logic [6:1] analog_enable,
    input wire logic parallel_port_placement_bit,
    input wire logic [2:0] parallel_data_in,
    input wire logic comparator_reference_output
);
    // Every check samples on the rising edge and rests during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // First access cycle: enabled but not yet answered.
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // The answer comes in the second access cycle and lasts one cycle.
    chk_ready_late: assert property (s_wait |=> pready)
        else $error("pready missing in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr raised without pready");
    chk_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data shown outside an answer");
    chk_unmapped_err: assert property (pready && paddr > 24 |-> pslverr)
        else $error("unmapped address answered without error");
    chk_bit0_zero: assert property (
        pready && paddr < 12 |-> prdata[0] == 1'b0)
        else $error("unimplemented bit zero read as one");
    chk_reset_state: assert property (
        $past(srst) |-> analog_enable == 6'h3F && pin_oe == 7'h00)
        else $error("wrong pin state after reset");
    chk_ref_off: assert property (
        comparator_reference_output [*3] |-> !pin_oe[5])
        else $error("line five driven while reference is out");
    chk_pdata_off: assert property (
        parallel_port_placement_bit [*3] |-> parallel_data_in == 3'h0)
        else $error("parallel data seen with placement bit high");
endmodule : gpio_port_assertions
bind gpio_port gpio_port_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_oe(pin_oe), .analog_enable(analog_enable),
    .parallel_port_placement_bit(parallel_port_placement_bit),
    .parallel_data_in(parallel_data_in),
    .comparator_reference_output(comparator_reference_output));
`default_nettype wire

/* File: tb/pin_model.sv */
// Model of the board around the port: pin wiring and outside drivers.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input wire logic clk,
    input wire logic [7:1] pin_out,
    input wire logic [7:1] pin_oe,
    input wire logic [7:1] ext_drive,
    input wire logic [7:1] ext_level,
    output logic [7:1] pin_in
);
    logic toggle = 1'b0;
    // A line nobody drives floats; a pattern that flips each cycle shows it.
    always_ff @(posedge clk) begin
        toggle <= ~toggle;
    end
    // The port wins where it drives, then the outside driver, else float.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
        | (~pin_oe & ~ext_drive & {7{toggle}});
endmodule : pin_model
`default_nettype wire

/* File: tb/gpio_port_test.sv */
// Self-checking bench of the port: registers, pins and overrides.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_test
    import gpio_port_pkg::*;
();
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, er, ref_out;
    logic [7:0] paddr = 8'h00, rd;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:1] pin_in, pin_out, pin_oe;
    logic [7:1] ext_drive = 7'h7F, ext_level = 7'h7F;
    logic [6:1] analog_enable;
    logic placement = 1'b1, comp1 = 1'b0, comp2 = 1'b0, addr5 = 1'b0;
    logic [2:0] pdata_out = 3'h0, pdata_in;
    logic pdata_drive = 1'b0;
    int err_count = 0, checked = 0;
    // Clock of 100 MHz.
    initial begin
        forever #5 clk = ~clk;
    end
    gpio_port u_dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .analog_enable(analog_enable),
        .parallel_port_placement_bit(placement),
        .comparator_one_output(comp1), .comparator_two_output(comp2),
        .parallel_address_bit_five(addr5), .parallel_data_out(pdata_out),
        .parallel_data_drive(pdata_drive), .parallel_data_in(pdata_in),
        .comparator_reference_output(ref_out));
    pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_drive(ext_drive), .ext_level(ext_level), .pin_in(pin_in));
    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    // Compares one value and counts the result.
    task automatic check(input string name, input logic [7:0] seen,
            input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) err_count++;
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so the next call never drives psel in this step.
        @(posedge clk);
    endtask : apb
    // Reads a register and compares it.
    task automatic rdc(input string name, input logic [7:0] a,
            input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(name, rd, exp);
    endtask : rdc
    // Lets registered pin outputs settle.
    task automatic wt;
        repeat (3) @(posedge clk);
    endtask : wt
    // Hang guard.
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_sim;
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("analog", {2'b0, analog_enable}, 8'h3F);
        rdc("dir", OFS_DIRECTION, DIRECTION_RESET);
        rdc("pin", OFS_PIN_LEVEL, 8'h80);
        apb(1, OFS_DIRECTION, 8'h01);
        apb(1, OFS_PIN_LEVEL, 8'hAB);
        rdc("latch", OFS_LATCH, 8'hAA);
        wt;
        check("out", {pin_out, 1'b0}, 8'hAA);
        check("oe", {pin_oe, 1'b0}, 8'hFE);
        rdc("dflt", OFS_SHARED_LOW, DEFAULT_REG_RESET);
        apb(1, OFS_SHARED_LOW, 8'h55);
        apb(1, OFS_WATCHDOG, 8'h10);
        rdc("sel", OFS_SHARED_LOW, ANALOG_LOW_RESET);
        apb(1, OFS_SHARED_LOW, 8'hFF);
        apb(1, OFS_SHARED_HIGH, 8'h0F);
        rdc("sel", OFS_SHARED_LOW, 8'hDF);
        apb(1, OFS_WATCHDOG, 8'h00);
        rdc("dflt", OFS_SHARED_LOW, 8'h55);
        check("analog", {2'b0, analog_enable}, 8'h00);
        rdc("pin", OFS_PIN_LEVEL, 8'hAA);
        apb(1, OFS_DIRECTION, 8'hFE);
        ext_level <= 7'h33;
        wt;
        check("oe", {pin_oe, 1'b0}, 8'h00);
        rdc("pin", OFS_PIN_LEVEL, 8'h66);
        apb(1, OFS_DIRECTION, 8'h00);
        apb(1, OFS_OVERRIDE, 8'h08);
        wt;
        check("oe", {pin_oe, 1'b0}, 8'hDE);
        check("ref", {7'h0, ref_out}, 8'h01);
        rdc("pin", OFS_PIN_LEVEL, 8'h8A);
        apb(0, 8'h1C, 8'h00);
        check("slverr", {er, rd[6:0]}, 8'h80);
        apb(1, OFS_DIRECTION, 8'hFE);
        apb(1, OFS_OVERRIDE, 8'h10);
        placement <= 1'b0;
        pdata_drive <= 1'b1;
        pdata_out <= 3'b101;
        wt;
        check("oe", {pin_oe, 1'b0}, 8'hE0);
        check("out", {pin_out[7:5], 5'h0}, 8'hA0);
        pdata_drive <= 1'b0;
        ext_level <= 7'h60;
        wt;
        check("pdin", {5'h0, pdata_in}, 8'h03);
        placement <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1, OFS_OVERRIDE, 8'h01 << i);
            for (int v = 0; v < 2; v++) begin
                comp1 <= v[0];
                comp2 <= v[0];
                addr5 <= v[0];
                wt;
                check("oe", {pin_oe, 1'b0}, (i == 1) ? 8'h02 : 8'h04);
                check("out", {7'h0, pin_out[(i == 1) ? 1 : 2]}, 8'(v));
            end
        end
        end_sim;
    end
endmodule : gpio_port_test
`default_nettype wire
